// ### nevh_pkg.sv
// Package: shared constants and types of the note escrow vend handshake
package nevh_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int CHAN_COUNT = 16;
  localparam int INHIBIT_COUNT = 4;
  localparam logic [3:0] LAST_DIRECT_CHAN = 4'h3;

  // ----------------------------------------------------------------
  // Timing, printed figures and derived counts
  // ----------------------------------------------------------------
  localparam longint CLOCK_HZ = 40000000;
  localparam longint PULSE_MS = 100;
  localparam longint ESCROW_S = 30;
  localparam longint OOS_S = 45;
  localparam longint PULSE_CYCLES_L = (CLOCK_HZ * PULSE_MS) / 1000;
  localparam longint ESCROW_CYCLES_L = CLOCK_HZ * ESCROW_S;
  localparam longint OOS_CYCLES_L = CLOCK_HZ * OOS_S;
  localparam int TIMER_WIDTH = 32;
  localparam logic [31:0] PULSE_CYCLES = PULSE_CYCLES_L[31:0];
  localparam logic [31:0] ESCROW_CYCLES = ESCROW_CYCLES_L[31:0];
  localparam logic [31:0] OOS_CYCLES = OOS_CYCLES_L[31:0];

  // ----------------------------------------------------------------
  // Device states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_PULSE1 = 3'b001,
    DEV_ESCROW = 3'b010,
    DEV_STACK = 3'b011,
    DEV_PULSE2 = 3'b100,
    DEV_RETURN = 3'b101,
    DEV_OOS = 3'b110,
    DEV_WAIT_LOW = 3'b111
  } nevh_dev_state_type;

  // ----------------------------------------------------------------
  // Host states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_VEND = 3'b001,
    HST_CLAIM = 3'b010,
    HST_DONE = 3'b011,
    HST_ABORT = 3'b100
  } nevh_host_state_type;

endpackage : nevh_pkg

// ### nevh_if.sv
// Interface: parallel lines between validator and vending host
`timescale 1ns/1ps
interface nevh_if;
  logic [15:0] chan;
  logic escrow;
  logic [3:0] inhibit;

  modport validator (
    output chan,
    input escrow,
    input inhibit
  );

  modport host (
    input chan,
    output escrow,
    output inhibit
  );
endinterface : nevh_if

// ### nevh_validator.sv
// Module: validator end of the note escrow vend handshake
//
// Summary of operation
// - Escrow handshake only in parallel or binary mode
// - Host holds escrow low while idle
// - Validated note: one 100ms channel pulse, hold
// - Host starts vend after first pulse
// - Stack note only after host confirms vend
// - No escrow high within 30s: return note
// - Escrow high: stack, second 100ms pulse
// - Host aborts without final pulse in 30s
// - Host drops escrow after vend completes
// - Channel inhibit during escrow returns note immediately
// - Channels above 3: all inhibits abort
// - Forced removal in escrow: 45s out of service
`timescale 1ns/1ps
module nevh_validator (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Link to host
  nevh_if.validator link,
  // Mode and note transport
  input wire logic escrow_mode_in,
  input wire logic note_valid_in,
  input wire logic [3:0] note_chan_in,
  input wire logic note_pulled_in,
  input wire logic stack_done_in,
  // Transport commands and status
  output logic stack_out,
  output logic return_out,
  output logic accept_ready_out,
  output logic out_of_service_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic escrow_meta;
  logic escrow_sync;
  logic [3:0] inhibit_meta;
  logic [3:0] inhibit_sync;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      escrow_meta <= 1'b0;
      escrow_sync <= 1'b0;
      inhibit_meta <= 4'h0;
      inhibit_sync <= 4'h0;
    end
    else
    begin
      escrow_meta <= link.escrow;
      escrow_sync <= escrow_meta;
      inhibit_meta <= link.inhibit;
      inhibit_sync <= inhibit_meta;
    end
  end

  // ----------------------------------------------------------------
  // State and timer
  // ----------------------------------------------------------------
  nevh_pkg::nevh_dev_state_type state;
  nevh_pkg::nevh_dev_state_type next_state;
  logic [31:0] timer;
  logic [3:0] held_chan;
  logic abort_req;
  logic timer_zero;

  assign timer_zero = (timer == 32'h0);

  // Notes on channels above 3 have no inhibit line of their own
  always_comb
  begin
    if (held_chan > nevh_pkg::LAST_DIRECT_CHAN)
      abort_req = &inhibit_sync;
    else
      abort_req = inhibit_sync[held_chan[1:0]];
  end

  always_comb
  begin
    next_state = state;
    case (state)
      nevh_pkg::DEV_IDLE:
        if (note_valid_in && escrow_mode_in && !escrow_sync)
          next_state = nevh_pkg::DEV_PULSE1;
      nevh_pkg::DEV_PULSE1:
        if (note_pulled_in)
          next_state = nevh_pkg::DEV_OOS;
        else if (abort_req)
          next_state = nevh_pkg::DEV_RETURN;
        else if (timer_zero)
          next_state = nevh_pkg::DEV_ESCROW;
      nevh_pkg::DEV_ESCROW:
        if (note_pulled_in)
          next_state = nevh_pkg::DEV_OOS;
        else if (abort_req)
          next_state = nevh_pkg::DEV_RETURN;
        else if (escrow_sync)
          next_state = nevh_pkg::DEV_STACK;
        else if (timer_zero)
          next_state = nevh_pkg::DEV_RETURN;
      nevh_pkg::DEV_STACK:
        if (stack_done_in)
          next_state = nevh_pkg::DEV_PULSE2;
      nevh_pkg::DEV_PULSE2:
        if (timer_zero)
          next_state = nevh_pkg::DEV_WAIT_LOW;
      nevh_pkg::DEV_RETURN:
        next_state = nevh_pkg::DEV_WAIT_LOW;
      nevh_pkg::DEV_OOS:
        if (timer_zero)
          next_state = nevh_pkg::DEV_WAIT_LOW;
      nevh_pkg::DEV_WAIT_LOW:
        if (!escrow_sync)
          next_state = nevh_pkg::DEV_IDLE;
      default:
        next_state = nevh_pkg::DEV_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state <= nevh_pkg::DEV_IDLE;
    else
      state <= next_state;
  end

  // Timer reloads on entry to each timed state, counts down inside
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      timer <= 32'h0;
    else if (next_state != state)
    begin
      case (next_state)
        nevh_pkg::DEV_PULSE1: timer <= nevh_pkg::PULSE_CYCLES - 32'h1;
        // Escrow window counts from the first pulse's start
        nevh_pkg::DEV_ESCROW: timer <= nevh_pkg::ESCROW_CYCLES
          - nevh_pkg::PULSE_CYCLES - 32'h1;
        nevh_pkg::DEV_PULSE2: timer <= nevh_pkg::PULSE_CYCLES - 32'h1;
        nevh_pkg::DEV_OOS: timer <= nevh_pkg::OOS_CYCLES - 32'h1;
        default: timer <= 32'h0;
      endcase
    end
    else if (!timer_zero)
      timer <= timer - 32'h1;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      held_chan <= 4'h0;
    // Capture only when a note is taken, so a refused strobe cannot move it
    else if (state == nevh_pkg::DEV_IDLE && next_state == nevh_pkg::DEV_PULSE1)
      held_chan <= note_chan_in;
  end

  // ----------------------------------------------------------------
  // Channel line decode
  // ----------------------------------------------------------------
  // One line per note value, so at most one line is ever high
  function automatic logic [15:0] nevh_chan_line(input logic [3:0] idx);
    return 16'h0001 << idx;
  endfunction : nevh_chan_line

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [15:0] chan_reg;
  logic stack_reg;
  logic return_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      chan_reg <= 16'h0000;
      stack_reg <= 1'b0;
      return_reg <= 1'b0;
    end
    else
    begin
      // The note input may move during the pulse; only the entry edge reads it
      if (next_state == nevh_pkg::DEV_PULSE1 && state == nevh_pkg::DEV_IDLE)
        chan_reg <= nevh_chan_line(note_chan_in);
      else if (next_state == nevh_pkg::DEV_PULSE1)
        chan_reg <= nevh_chan_line(held_chan);
      else if (next_state == nevh_pkg::DEV_PULSE2)
        chan_reg <= nevh_chan_line(held_chan);
      else
        chan_reg <= 16'h0000;
      stack_reg <= (next_state == nevh_pkg::DEV_STACK);
      return_reg <= (next_state == nevh_pkg::DEV_RETURN);
    end
  end

  assign link.chan = chan_reg;
  assign stack_out = stack_reg;
  assign return_out = return_reg;
  assign accept_ready_out = (state == nevh_pkg::DEV_IDLE);
  assign out_of_service_out = (state == nevh_pkg::DEV_OOS);

endmodule : nevh_validator

// ### nevh_host.sv
// Module: vending host end of the note escrow vend handshake
`timescale 1ns/1ps
module nevh_host (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Link to validator
  nevh_if.host link,
  // Vend control from machine logic
  input wire logic vend_done_in,
  input wire logic abort_in,
  // Status to machine logic
  output logic credit_out,
  output logic [3:0] credit_chan_out,
  output logic vend_ok_out,
  output logic vend_abort_out
);

  // ----------------------------------------------------------------
  // Channel synchroniser and edge detect
  // ----------------------------------------------------------------
  logic [15:0] chan_meta;
  logic [15:0] chan_sync;
  logic [15:0] chan_prev;
  logic pulse_rise;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      chan_meta <= 16'h0000;
      chan_sync <= 16'h0000;
      chan_prev <= 16'h0000;
    end
    else
    begin
      chan_meta <= link.chan;
      chan_sync <= chan_meta;
      chan_prev <= chan_sync;
    end
  end

  assign pulse_rise = |(chan_sync & ~chan_prev);

  function automatic logic [3:0] nevh_encode(input logic [15:0] onehot);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 16; i++)
      if (onehot[i])
        idx = 4'(i);
    return idx;
  endfunction : nevh_encode

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  nevh_pkg::nevh_host_state_type state;
  logic [31:0] timer;
  logic [3:0] chan_held;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= nevh_pkg::HST_IDLE;
      timer <= 32'h0;
      chan_held <= 4'h0;
    end
    else
    begin
      case (state)
        nevh_pkg::HST_IDLE:
          if (pulse_rise)
          begin
            chan_held <= nevh_encode(chan_sync & ~chan_prev);
            state <= nevh_pkg::HST_VEND;
          end
        nevh_pkg::HST_VEND:
          if (abort_in)
            state <= nevh_pkg::HST_ABORT;
          else if (vend_done_in)
          begin
            timer <= nevh_pkg::ESCROW_CYCLES - 32'h1;
            state <= nevh_pkg::HST_CLAIM;
          end
        nevh_pkg::HST_CLAIM:
          if (pulse_rise)
            state <= nevh_pkg::HST_DONE;
          else if (timer == 32'h0)
            state <= nevh_pkg::HST_ABORT;
          else
            timer <= timer - 32'h1;
        nevh_pkg::HST_DONE:
          state <= nevh_pkg::HST_IDLE;
        nevh_pkg::HST_ABORT:
          if (chan_sync == 16'h0000)
            state <= nevh_pkg::HST_IDLE;
        default:
          state <= nevh_pkg::HST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link and status outputs
  // ----------------------------------------------------------------
  logic escrow_reg;
  logic [3:0] inhibit_reg;
  logic credit_reg;
  logic ok_reg;
  logic ab_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      escrow_reg <= 1'b0;
      inhibit_reg <= 4'h0;
      credit_reg <= 1'b0;
      ok_reg <= 1'b0;
      ab_reg <= 1'b0;
    end
    else
    begin
      escrow_reg <= (state == nevh_pkg::HST_CLAIM);
      if (state == nevh_pkg::HST_VEND && abort_in)
      begin
        if (chan_held > nevh_pkg::LAST_DIRECT_CHAN)
          inhibit_reg <= 4'hf;
        else
          inhibit_reg <= 4'h1 << chan_held[1:0];
      end
      else if (state == nevh_pkg::HST_IDLE)
        inhibit_reg <= 4'h0;
      credit_reg <= (state == nevh_pkg::HST_IDLE) && pulse_rise;
      ok_reg <= (state == nevh_pkg::HST_CLAIM) && pulse_rise;
      ab_reg <= (state == nevh_pkg::HST_CLAIM) && !pulse_rise && timer == 32'h0;
    end
  end

  assign link.escrow = escrow_reg;
  assign link.inhibit = inhibit_reg;
  assign credit_out = credit_reg;
  assign credit_chan_out = chan_held;
  assign vend_ok_out = ok_reg;
  assign vend_abort_out = ab_reg;

endmodule : nevh_host

// ### nevh_checker.sv
// Checker: wire rules of the link between validator and host
`timescale 1ns/1ps
module nevh_checker (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Link signals
  input wire logic [15:0] chan,
  input wire logic escrow,
  input wire logic [3:0] inhibit
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [31:0] cnt;
  logic [3:0] last_idx;
  logic was_on, was_esc, any_note, seen_first, second_seen;

  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt <= 32'h0;
    else if (chan != 16'h0000)
      cnt <= cnt + 32'h1;
    else
      cnt <= 32'h0;
  end

  // Clears come first so that a rise in the same cycle wins
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      last_idx <= 4'h0;
      {was_on, was_esc, any_note, seen_first, second_seen} <= 5'h0;
    end
    else
    begin
      was_on <= chan != 16'h0000;
      was_esc <= escrow;
      if (!escrow)
        second_seen <= 1'b0;
      if (was_esc && !escrow)
        seen_first <= 1'b0;
      if (chan != 16'h0000 && !was_on)
      begin
        any_note <= 1'b1;
        if (escrow)
          second_seen <= 1'b1;
        else
          seen_first <= 1'b1;
        for (int i = 0; i < 16; i++)
          if (chan[i])
            last_idx <= i[3:0];
      end
    end
  end

  sequence chan_rise_s;
    $past(chan) == 16'h0000 && chan != 16'h0000;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  one_hot_a: assert property ($onehot0(chan))
    else $error("more than one channel line high");
  chan_steady_a: assert property ((chan != 16'h0000 && $past(chan) != 16'h0000) |->
    chan == $past(chan)) else $error("channel changed inside a pulse");
  pulse_len_a: assert property (cnt <= nevh_pkg::PULSE_CYCLES)
    else $error("channel pulse too long");
  claim_after_a: assert property ($rose(escrow) |-> seen_first)
    else $error("escrow raised with no note pulse");
  final_chan_a: assert property (chan_rise_s ##0 escrow |-> chan[last_idx])
    else $error("final pulse on another channel");
  one_final_a: assert property (chan_rise_s ##0 escrow |-> !second_seen)
    else $error("second final pulse before escrow low");
  inhibit_shape_a: assert property (inhibit != 4'h0 |->
    $onehot(inhibit) || inhibit == 4'hf) else $error("bad inhibit pattern");
  inhibit_pair_a: assert property ((inhibit != 4'h0 && any_note) |->
    (last_idx < 4'h4 ? inhibit[last_idx[1:0]] : inhibit == 4'hf))
    else $error("inhibit does not match note channel");
endmodule : nevh_checker

// ### tb.sv
// Testbench: validator and host joined over the link
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module tb;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic escrow_mode_in = 1'b0, note_valid_in = 1'b0, note_pulled_in = 1'b0;
  logic stack_done_in = 1'b0, vend_done_in = 1'b0, abort_in = 1'b0;
  logic [3:0] note_chan_in = 4'h0;
  logic stack_out, return_out, accept_ready_out, out_of_service_out;
  logic credit_out, vend_ok_out, vend_abort_out;
  logic [3:0] credit_chan_out;
  int bad_count = 0;
  int check_count = 0;

  nevh_if link ();
  nevh_validator i_nevh_validator (.mclk_in, .rst_n_in, .link(link), .escrow_mode_in,
    .note_valid_in, .note_chan_in, .note_pulled_in, .stack_done_in, .stack_out,
    .return_out, .accept_ready_out, .out_of_service_out);
  nevh_host i_nevh_host (.mclk_in, .rst_n_in, .link(link), .vend_done_in, .abort_in,
    .credit_out, .credit_chan_out, .vend_ok_out, .vend_abort_out);
  nevh_checker i_nevh_checker (.mclk_in, .rst_n_in, .chan(link.chan),
    .escrow(link.escrow), .inhibit(link.inhibit));

  always #12.5 mclk_in = ~mclk_in;

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task results;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task do_reset;
    @(posedge mclk_in) rst_n_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(negedge mclk_in);
  endtask : do_reset

  task note(input logic [3:0] c);
    @(posedge mclk_in);
    note_valid_in <= 1'b1;
    note_chan_in <= c;
    @(posedge mclk_in) note_valid_in <= 1'b0;
  endtask : note

  function automatic logic cond(input int w);
    case (w)
      0: return link.chan != 16'h0000;
      1: return credit_out;
      2: return return_out;
      3: return out_of_service_out;
      default: return link.inhibit != 4'h0;
    endcase
  endfunction : cond

  // Bounded wait so a missing answer shows as a mismatch, not a hang
  task wait_for(input int w);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk_in);
      n++;
    end
    while (cond(w) !== 1'b1 && n < 40);
    `CHK("wait", 1'b1, cond(w))
  endtask : wait_for

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    do_reset;
    `CHK("escrow idle", 1'b0, link.escrow)
    note(4'h1);
    repeat (4) @(negedge mclk_in);
    `CHK("mode off", 16'h0000, link.chan)
    @(posedge mclk_in) escrow_mode_in <= 1'b1;
    for (int c = 0; c < 16; c++)
    begin
      do_reset;
      note(c[3:0]);
      wait_for(0);
      `CHK("chan", 16'h0001 << c, link.chan)
      note(c[3:0] ^ 4'h1);
      @(negedge mclk_in);
      `CHK("busy note", 16'h0001 << c, link.chan)
      wait_for(1);
      `CHK("credit chan", c[3:0], credit_chan_out)
      @(posedge mclk_in) abort_in <= 1'b1;
      wait_for(4);
      `CHK("inhibit", (c < 4) ? (4'h1 << c) : 4'hf, link.inhibit)
      wait_for(2);
      `CHK("no stack", 1'b0, stack_out)
      `CHK("return chan", 16'h0000, link.chan)
      `CHK("no final", 1'b0, vend_ok_out)
      `CHK("no timeout", 1'b0, vend_abort_out)
      @(posedge mclk_in) abort_in <= 1'b0;
      repeat (3) @(negedge mclk_in);
      `CHK("ready again", 1'b1, accept_ready_out)
    end
    do_reset;
    note(4'h2);
    wait_for(0);
    @(posedge mclk_in) note_pulled_in <= 1'b1;
    @(posedge mclk_in) note_pulled_in <= 1'b0;
    wait_for(3);
    `CHK("not ready", 1'b0, accept_ready_out)
    repeat (50000) @(negedge mclk_in);
    `CHK("still out", 1'b1, out_of_service_out)
    results;
  end

  initial
  begin
    #2000000;
    bad_count++;
    $display("Watchdog expired");
    results;
  end
endmodule : tb
